// file: tws_slave_rx.sv
// Two-wire bus slave receiver with AXI4-Lite register access.
// Assumes open-drain pads resolved outside; SCL and SDA arrive asynchronously.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tws_slave_rx
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic [tws_pkg::TWS_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [tws_pkg::TWS_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic sleep_in,
    input wire logic arb_lost_in,
    output logic wake_out,
    output logic xmt_enter_out,
    output logic start_go_out
);
    import tws_pkg::*;

    function automatic logic tws_mapped(input logic [3:0] a);
        return a[1:0] == 2'h0;
    endfunction : tws_mapped

    // ==========================================
    // Pin synchronisers and glitch filter
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic scl_f_q;
    logic sda_f_q;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'h1;
            sda_f_q <= 1'h1;
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
        end
        else if (clk_en_in)
        begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            if (scl_s_q[1] == scl_s_q[2])
                scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2])
                sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    assign scl_rise = scl_f_q && !scl_p_q;
    assign scl_fall = !scl_f_q && scl_p_q;
    assign bus_start = scl_f_q && scl_p_q && !sda_f_q && sda_p_q;
    assign bus_stop = scl_f_q && scl_p_q && sda_f_q && !sda_p_q;

    // ==========================================
    // Register state
    logic [7:0] oar_q;
    logic flag_q;
    logic ack_en_q;
    logic sta_q;
    logic sto_q;
    logic wc_q;
    logic en_q;
    logic ie_q;
    logic [7:0] data_q;
    logic [7:0] stat_q;
    logic start_go_q;
    logic busy_q;

    // ==========================================
    // AXI4-Lite slave
    logic aw_v_q;
    logic [3:0] aw_a_q;
    logic w_v_q;
    logic [7:0] w_d_q;
    logic w_s_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic wr_ok;
    logic wr_ctrl;
    logic wr_data;
    logic [7:0] ctrl_rd;
    logic [7:0] rd_byte;

    // Writes wait for both channels; no new address taken until B drains
    // Masked while frozen, so no handshake completes that the flops would miss
    assign s_axi_awready_out = !aw_v_q && !bvalid_q && clk_en_in;
    assign s_axi_wready_out = !w_v_q && !bvalid_q && clk_en_in;
    assign s_axi_bvalid_out = bvalid_q && clk_en_in;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = !rvalid_q && clk_en_in;
    assign s_axi_rvalid_out = rvalid_q && clk_en_in;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign wr_fire = aw_v_q && w_v_q;
    assign wr_ok = wr_fire && w_s_q && tws_mapped(aw_a_q);
    assign wr_ctrl = wr_ok && (aw_a_q == TWS_OFF_CTRL);
    assign wr_data = wr_ok && (aw_a_q == TWS_OFF_DATA);

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            aw_v_q <= 1'h0;
            aw_a_q <= 4'h0;
            w_v_q <= 1'h0;
            w_d_q <= 8'h00;
            w_s_q <= 1'h0;
            bvalid_q <= 1'h0;
            bresp_q <= TWS_RESP_OKAY;
        end
        else if (clk_en_in)
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_v_q <= 1'h1;
                aw_a_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_v_q <= 1'h1;
                w_d_q <= s_axi_wdata_in[7:0];
                w_s_q <= s_axi_wstrb_in[0];
            end
            if (wr_fire)
            begin
                aw_v_q <= 1'h0;
                w_v_q <= 1'h0;
                bvalid_q <= 1'h1;
                bresp_q <= tws_mapped(aw_a_q) ? TWS_RESP_OKAY : TWS_RESP_SLVERR;
            end
            else if (s_axi_bready_in)
                bvalid_q <= 1'h0;
        end
    end

    always_comb
    begin
        ctrl_rd = 8'h00;
        ctrl_rd[TWS_B_INT] = flag_q;
        ctrl_rd[TWS_B_ACK] = ack_en_q;
        ctrl_rd[TWS_B_STA] = sta_q;
        ctrl_rd[TWS_B_STO] = sto_q;
        ctrl_rd[TWS_B_WC] = wc_q;
        ctrl_rd[TWS_B_EN] = en_q;
        ctrl_rd[TWS_B_IE] = ie_q;
    end

    always_comb
    begin
        case (s_axi_araddr_in)
            TWS_OFF_ADDR: rd_byte = oar_q;
            TWS_OFF_CTRL: rd_byte = ctrl_rd;
            // Status is only meaningful while the flag is up
            TWS_OFF_STAT: rd_byte = flag_q ? stat_q : TWS_CODE_NONE;
            TWS_OFF_DATA: rd_byte = data_q;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rvalid_q <= 1'h0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= TWS_RESP_OKAY;
        end
        else if (clk_en_in)
        begin
            if (s_axi_arvalid_in && !rvalid_q)
            begin
                rvalid_q <= 1'h1;
                rdata_q <= {24'h00_0000, rd_byte};
                rresp_q <= tws_mapped(s_axi_araddr_in) ? TWS_RESP_OKAY : TWS_RESP_SLVERR;
            end
            else if (s_axi_rready_in)
                rvalid_q <= 1'h0;
        end
    end

    // ==========================================
    // Receiver state machine
    tws_state_t state_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic ack_q;
    logic ph_q;
    logic gc_q;
    logic addr_ph_q;
    logic nxt_idle_q;
    logic arb_q;
    logic xmt_enter_q;
    logic byte_done;
    logic [7:0] new_byte;
    logic own_hit;
    logic gc_hit;
    logic ack_end;
    logic stop_evt;
    logic flag_set;
    logic [7:0] code_d;

    assign new_byte = {sh_q[6:0], sda_f_q};
    assign byte_done = scl_rise && (cnt_q == TWS_LAST_BIT)
        && (state_q == S_ADDR || state_q == S_DATA);
    assign own_hit = new_byte[7:1] == oar_q[7:1];
    assign gc_hit = (new_byte[7:1] == TWS_GC_ADDR) && oar_q[TWS_B_GCE];
    assign ack_end = (state_q == S_ACK) && scl_fall && ph_q;
    assign stop_evt = (bus_start || bus_stop) && en_q
        && (state_q == S_DATA || state_q == S_ACK);
    assign flag_set = ack_end || stop_evt;

    always_comb
    begin
        if (!ack_end)
            code_d = TWS_CODE_STOP;
        else if (addr_ph_q && gc_q)
            code_d = arb_q ? TWS_CODE_ARB_GC : TWS_CODE_GC;
        else if (addr_ph_q)
            code_d = arb_q ? TWS_CODE_ARB_OWN : TWS_CODE_OWN;
        else if (gc_q)
            code_d = ack_q ? TWS_CODE_GC_ACK : TWS_CODE_GC_NACK;
        else
            code_d = ack_q ? TWS_CODE_DAT_ACK : TWS_CODE_DAT_NACK;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q <= S_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            ack_q <= 1'h0;
            ph_q <= 1'h0;
            gc_q <= 1'h0;
            addr_ph_q <= 1'h0;
            nxt_idle_q <= 1'h0;
            xmt_enter_q <= 1'h0;
        end
        else if (clk_en_in)
        begin
            xmt_enter_q <= 1'h0;
            if (!en_q || sto_q)
                state_q <= S_IDLE;
            else if (bus_start)
            begin
                state_q <= S_ADDR;
                cnt_q <= 3'h0;
                ph_q <= 1'h0;
            end
            else if (bus_stop)
                state_q <= S_IDLE;
            else
            begin
                unique case (state_q)
                    S_IDLE: cnt_q <= 3'h0;
                    S_ADDR, S_DATA:
                    begin
                        if (scl_rise)
                        begin
                            sh_q <= new_byte;
                            cnt_q <= cnt_q + 3'h1;
                        end
                        if (byte_done && state_q == S_DATA)
                        begin
                            ack_q <= ack_en_q;
                            state_q <= S_ACK;
                        end
                        else if (byte_done)
                        begin
                            // Ack enable is checked at each address byte
                            if (ack_en_q && (own_hit || gc_hit) && !new_byte[0])
                            begin
                                ack_q <= 1'h1;
                                gc_q <= new_byte[7:1] == TWS_GC_ADDR;
                                addr_ph_q <= 1'h1;
                                state_q <= S_ACK;
                            end
                            else
                            begin
                                xmt_enter_q <= ack_en_q && (own_hit || gc_hit);
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_ACK:
                    begin
                        // First fall starts the ack slot, second ends it
                        if (scl_fall && !ph_q)
                            ph_q <= 1'h1;
                        else if (scl_fall)
                        begin
                            ph_q <= 1'h0;
                            nxt_idle_q <= !addr_ph_q && !ack_q;
                            state_q <= S_HOLD;
                        end
                    end
                    S_HOLD:
                    begin
                        if (!flag_q)
                        begin
                            state_q <= nxt_idle_q ? S_IDLE : S_DATA;
                            cnt_q <= 3'h0;
                            addr_ph_q <= 1'h0;
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Control, status and data registers
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            flag_q <= 1'h0;
            ack_en_q <= 1'h0;
            sta_q <= 1'h0;
            sto_q <= 1'h0;
            wc_q <= 1'h0;
            en_q <= 1'h0;
            ie_q <= 1'h0;
            stat_q <= TWS_CODE_NONE;
        end
        else if (clk_en_in)
        begin
            if (start_go_q)
                sta_q <= 1'h0;
            // Stop request in slave mode only releases the bus
            if (sto_q)
                sto_q <= 1'h0;
            if (wr_ctrl)
            begin
                ack_en_q <= w_d_q[TWS_B_ACK];
                sta_q <= w_d_q[TWS_B_STA];
                sto_q <= w_d_q[TWS_B_STO];
                en_q <= w_d_q[TWS_B_EN];
                ie_q <= w_d_q[TWS_B_IE];
            end
            // Hardware set wins over a same-cycle clear
            if (flag_set)
                flag_q <= 1'h1;
            else if (wr_ctrl && w_d_q[TWS_B_INT])
                flag_q <= 1'h0;
            if (flag_set)
                stat_q <= code_d;
            if (wr_data)
                wc_q <= !flag_q;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            oar_q <= TWS_RST_ADDR;
            data_q <= TWS_RST_DATA;
        end
        else if (clk_en_in)
        begin
            if (wr_ok && aw_a_q == TWS_OFF_ADDR)
                oar_q <= w_d_q;
            if (wr_data && flag_q)
                data_q <= w_d_q;
            else if (byte_done && state_q == S_DATA && !sleep_in)
                data_q <= new_byte;
        end
    end

    // ==========================================
    // Bus start hand-off and arbitration history
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            busy_q <= 1'h0;
            start_go_q <= 1'h0;
            arb_q <= 1'h0;
        end
        else if (clk_en_in)
        begin
            if (bus_start)
                busy_q <= 1'h1;
            else if (bus_stop)
                busy_q <= 1'h0;
            // Master logic is told once the bus is free
            start_go_q <= sta_q && en_q && !busy_q && !start_go_q;
            if (arb_lost_in)
                arb_q <= 1'h1;
            else if (bus_stop || (ack_end && addr_ph_q))
                arb_q <= 1'h0;
        end
    end

    // ==========================================
    // Pin drive
    // Deep sleep is modelled with clk_in still sampling the bus
    assign scl_out = 1'h0;
    assign sda_out = 1'h0;
    assign scl_oe_out = (state_q == S_HOLD) && flag_q;
    assign sda_oe_out = (state_q == S_ACK) && ph_q && ack_q;
    assign wake_out = sleep_in && flag_q;
    assign xmt_enter_out = xmt_enter_q;
    assign start_go_out = start_go_q;

    // ==========================================
    // Checks
    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_scl_stretch: assert property (
        clk_en_in && ack_end |=> scl_oe_out && flag_q)
        else $error("SCL not stretched after ack slot");
    chk_flag_clear: assert property (
        clk_en_in && wr_ctrl && w_d_q[TWS_B_INT] && !flag_set |=> !flag_q)
        else $error("flag not cleared by write of one");
    chk_set_wins: assert property (
        clk_en_in && flag_set |=> flag_q)
        else $error("flag set lost");
    chk_no_ack_off: assert property (
        clk_en_in && byte_done && state_q == S_ADDR && !ack_en_q |=> state_q != S_ACK)
        else $error("address acked with ack disabled");
    chk_gc_ignore: assert property (
        clk_en_in && byte_done && state_q == S_ADDR && new_byte[7:1] == TWS_GC_ADDR
        && !oar_q[TWS_B_GCE] && oar_q[7:1] != TWS_GC_ADDR |=> state_q == S_IDLE)
        else $error("general call answered while disabled");
    chk_own_match: assert property (
        clk_en_in && byte_done && state_q == S_ADDR && en_q && !sto_q && ack_en_q
        && own_hit && !new_byte[0] |=> state_q == S_ACK && ack_q)
        else $error("own address write not acked");
    chk_data_nack: assert property (
        clk_en_in && byte_done && state_q == S_DATA && en_q && !sto_q
        && !ack_en_q |=> !ack_q && !sda_oe_out)
        else $error("data acked with ack disabled");
    chk_nack_idle: assert property (
        clk_en_in && state_q == S_HOLD && nxt_idle_q && !flag_q && en_q
        && !sto_q |=> state_q == S_IDLE)
        else $error("not released after NACKed byte");
    chk_addr_status: assert property (
        clk_en_in && ack_end && addr_ph_q |=> stat_q[7:4] == 4'h6 || stat_q[7:4] == 4'h7)
        else $error("bad status after address");
    chk_sleep_data: assert property (
        clk_en_in && sleep_in && !wr_data |=> $stable(data_q))
        else $error("data register changed in sleep");

    cov_addr_ack: cover property (clk_en_in && ack_end && addr_ph_q);
    cov_data_nack: cover property (clk_en_in && ack_end && !addr_ph_q && !ack_q);
    cov_start_go: cover property (start_go_out);
endmodule : tws_slave_rx

// file: tws_pkg.sv
// Constants for the two-wire slave receiver block.
// Assumes a 32-bit AXI4-Lite register slave with a 4-bit byte address.
package tws_pkg;
    // ==========================================
    // Register map
    localparam int TWS_AW = 4;
    localparam logic [3:0] TWS_OFF_ADDR = 4'h0;
    localparam logic [3:0] TWS_OFF_CTRL = 4'h4;
    localparam logic [3:0] TWS_OFF_STAT = 4'h8;
    localparam logic [3:0] TWS_OFF_DATA = 4'hC;
    localparam logic [7:0] TWS_RST_ADDR = 8'h00;
    localparam logic [7:0] TWS_RST_DATA = 8'hFF;
    localparam logic [1:0] TWS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TWS_RESP_SLVERR = 2'h2;

    // ==========================================
    // Control and address register field positions
    localparam int TWS_B_INT = 7;
    localparam int TWS_B_ACK = 6;
    localparam int TWS_B_STA = 5;
    localparam int TWS_B_STO = 4;
    localparam int TWS_B_WC = 3;
    localparam int TWS_B_EN = 2;
    localparam int TWS_B_IE = 0;
    localparam int TWS_B_GCE = 0;

    // ==========================================
    // Status codes
    localparam logic [7:0] TWS_CODE_OWN = 8'h60;
    localparam logic [7:0] TWS_CODE_ARB_OWN = 8'h68;
    localparam logic [7:0] TWS_CODE_GC = 8'h70;
    localparam logic [7:0] TWS_CODE_ARB_GC = 8'h78;
    localparam logic [7:0] TWS_CODE_DAT_ACK = 8'h80;
    localparam logic [7:0] TWS_CODE_DAT_NACK = 8'h88;
    localparam logic [7:0] TWS_CODE_GC_ACK = 8'h90;
    localparam logic [7:0] TWS_CODE_GC_NACK = 8'h98;
    localparam logic [7:0] TWS_CODE_STOP = 8'hA0;
    localparam logic [7:0] TWS_CODE_NONE = 8'hF8;
    localparam logic [6:0] TWS_GC_ADDR = 7'h00;
    localparam logic [2:0] TWS_LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_DATA,
        S_ACK,
        S_HOLD
    } tws_state_t;
endpackage : tws_pkg

// file: tws_bus_master.sv
// Two-wire bus master transmitter model facing the slave receiver.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module tws_bus_master
(
    input wire logic scl_line_in,
    input wire logic sda_line_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    // ==========================================
    // Bit engine, 160 ns per bit, clock idle between frames
    initial
    begin
        scl_low_out = 1'h0;
        sda_low_out = 1'h0;
    end
    task automatic put_bit(input logic v, output logic s);
        #40 sda_low_out = !v;
        #40 scl_low_out = 1'h0;
        // Slave may stretch, so wait for the line itself
        wait (scl_line_in === 1'h1);
        #40 s = sda_line_in;
        #40 scl_low_out = 1'h1;
    endtask : put_bit
    task automatic start_cond();
        // Pin changes kept off the sampling clock edges
        #3 sda_low_out = 1'h1;
        #80 scl_low_out = 1'h1;
    endtask : start_cond
    task automatic stop_cond();
        #43 sda_low_out = 1'h1;
        #40 scl_low_out = 1'h0;
        wait (scl_line_in === 1'h1);
        #80 sda_low_out = 1'h0;
        #80;
    endtask : stop_cond
    // Msb first, then a released bit for the slave's answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        #3;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'h1, s);
        ack = !s;
        #80;
    endtask : send_byte
endmodule : tws_bus_master

// file: tws_slave_rx_tb_top.sv
// Self-checking bench: AXI software model against the slave receiver.
// Assumes tws_bus_master as far side; released lines read high.
`timescale 1ns/1ps
module tws_slave_rx_tb_top;
    import tws_pkg::*;
    logic clk_in = 1'h0, resetn_in = 1'h0, clk_en_in = 1'h1;
    logic [TWS_AW-1:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, sleep_in = 1'h0, arb_lost_in = 1'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd_q;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, scl_out, scl_oe_out, sda_out, sda_oe_out, wake_out;
    logic xmt_enter_out, start_go_out, m_scl_low, m_sda_low, scl_in, sda_in;
    logic seen_xmt = 1'h0, seen_go = 1'h0, ack_q = 1'h0;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp_q;
    logic [7:0] own_q = 8'h00, exp_q = 8'h00, last_d = TWS_RST_DATA;
    logic [7:0] rst_tab [4] = '{TWS_RST_ADDR, 8'h00, TWS_CODE_NONE, TWS_RST_DATA};
    integer seed = 32'h75D2AF47;
    int error_cnt = 0, tests_run = 0;

    assign scl_in = !(m_scl_low | scl_oe_out);
    assign sda_in = !(m_sda_low | sda_oe_out);
    always #5 clk_in = !clk_in;
    tws_slave_rx dut_u (.*);
    tws_bus_master u_mst (.scl_line_in(scl_in), .sda_line_in(sda_in),
        .scl_low_out(m_scl_low), .sda_low_out(m_sda_low));

    // One-cycle pulses are caught here so later reads cannot miss them
    always @(posedge clk_in)
    begin
        if (xmt_enter_out === 1'h1) seen_xmt <= 1'h1;
        if (start_go_out === 1'h1) seen_go <= 1'h1;
    end

    // ==========================================
    // Reference model and bus tasks
    function automatic logic [7:0] exp_stat(logic [7:0] ab, logic arb);
        if (!ack_q || ab[0]) return 8'h00;
        if (ab[7:1] == own_q[7:1]) return arb ? TWS_CODE_ARB_OWN : TWS_CODE_OWN;
        if (ab[7:1] == TWS_GC_ADDR && own_q[0]) return arb ? TWS_CODE_ARB_GC : TWS_CODE_GC;
        return 8'h00;
    endfunction : exp_stat
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        while (aw || w)
        begin
            @(posedge clk_in);
            if (aw && s_axi_awready_out === 1'h1)
            begin
                aw = 1'h0;
                s_axi_awvalid_in <= 1'h0;
            end
            if (w && s_axi_wready_out === 1'h1)
            begin
                w = 1'h0;
                s_axi_wvalid_in <= 1'h0;
            end
        end
        do @(posedge clk_in); while (s_axi_bvalid_out !== 1'h1);
        resp_q = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
        if (a == TWS_OFF_ADDR) own_q = d;
        if (a == TWS_OFF_CTRL) ack_q = d[TWS_B_ACK];
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in <= 1'h1;
        do @(posedge clk_in); while (s_axi_arready_out !== 1'h1);
        s_axi_arvalid_in <= 1'h0;
        do @(posedge clk_in); while (s_axi_rvalid_out !== 1'h1);
        rd_q = s_axi_rdata_out;
        resp_q = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
    endtask : axi_rd
    task automatic addr_frame(input logic [7:0] ab, input logic arb);
        logic ack;
        exp_q = exp_stat(ab, arb);
        if (arb)
        begin
            @(posedge clk_in);
            arb_lost_in <= 1'h1;
            @(posedge clk_in);
            arb_lost_in <= 1'h0;
        end
        u_mst.start_cond();
        u_mst.send_byte(ab, ack);
        check(ack, exp_q != 8'h00, "address ack");
        axi_rd(TWS_OFF_STAT);
        check(rd_q, exp_q == 8'h00 ? TWS_CODE_NONE : exp_q, "address status");
        if (exp_q != 8'h00)
        begin
            check(scl_oe_out, 1'h1, "stretch");
            check({scl_out, sda_out}, 2'h0, "open drain level");
            check(wake_out, sleep_in, "wake");
            axi_wr(TWS_OFF_CTRL, 8'hC4);
            repeat (2) @(posedge clk_in);
            check(scl_oe_out, 1'h0, "stretch release");
        end
    endtask : addr_frame
    task automatic data_byte(input logic [7:0] clr);
        logic [7:0] d;
        logic ack;
        d = 8'($random(seed));
        u_mst.send_byte(d, ack);
        check(ack, ack_q, "data ack");
        axi_rd(TWS_OFF_STAT);
        check(rd_q, ack_q ? TWS_CODE_DAT_ACK : TWS_CODE_DAT_NACK, "data status");
        if (!sleep_in) last_d = d;
        axi_rd(TWS_OFF_DATA);
        check(rd_q, last_d, "data byte");
        axi_wr(TWS_OFF_CTRL, clr);
    endtask : data_byte
    task automatic end_frame();
        u_mst.stop_cond();
        axi_rd(TWS_OFF_STAT);
        check(rd_q, exp_q != 8'h00 ? TWS_CODE_STOP : TWS_CODE_NONE, "after stop");
        if (exp_q != 8'h00) axi_wr(TWS_OFF_CTRL, 8'hC4);
        $display("test ended, %0d comparisons so far", tests_run);
    endtask : end_frame
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ==========================================
    // Main sequence
    initial
    begin
        logic [7:0] own;
        own = {7'($random(seed)) | 7'h01, 1'h0};
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            axi_rd(4'(i * 4));
            check(rd_q, rst_tab[i], "reset value");
        end
        axi_wr(4'h2, 8'hFF);
        check(resp_q, TWS_RESP_SLVERR, "misaligned write");
        axi_rd(4'h5);
        check(resp_q, TWS_RESP_SLVERR, "misaligned read");
        axi_wr(TWS_OFF_ADDR, own);
        axi_wr(TWS_OFF_CTRL, 8'h44);
        addr_frame({own[7:1], 1'h0}, 1'h0);
        data_byte(8'h84);
        data_byte(8'hE4);
        exp_q = 8'h00;
        end_frame();
        check(seen_go, 1'h1, "start after nack");
        addr_frame(8'h00, 1'h0);
        end_frame();
        axi_wr(TWS_OFF_CTRL, 8'h04);
        addr_frame({own[7:1], 1'h0}, 1'h0);
        end_frame();
        axi_wr(TWS_OFF_ADDR, own | 8'h01);
        axi_wr(TWS_OFF_CTRL, 8'h44);
        addr_frame(8'h00, 1'h1);
        end_frame();
        addr_frame({own[7:1], 1'h0}, 1'h1);
        end_frame();
        addr_frame(8'h00, 1'h0);
        end_frame();
        addr_frame({own[7:1], 1'h1}, 1'h0);
        end_frame();
        check(seen_xmt, 1'h1, "read hand-off");
        @(posedge clk_in);
        sleep_in <= 1'h1;
        addr_frame({own[7:1], 1'h0}, 1'h0);
        data_byte(8'hC4);
        @(posedge clk_in);
        sleep_in <= 1'h0;
        end_frame();
        // A read offered while frozen must wait, not be lost
        @(posedge clk_in);
        clk_en_in <= 1'h0;
        fork
            axi_rd(TWS_OFF_CTRL);
            begin
                repeat (6) @(posedge clk_in);
                clk_en_in <= 1'h1;
            end
        join
        check(rd_q, 32'h0000_0044, "frozen read");
        wrap_up();
    end

    // Whole run needs well under 100 us
    initial
    begin
        #500000;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : tws_slave_rx_tb_top
